//--- core/code_space_decode.sv
// decides whether a code address is fetched from internal memory
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defs.svh"
module code_space_decode (
    // strap and address
    input wire logic clk,
    input wire logic rstn,
    input wire logic code_space_select_pin,
    input wire logic [15:0] code_addr,
    // decision
    output logic internal_hit
);
    logic strap_reg;
    logic seen_reg;

    // catch the strap once after reset release
    always_ff @(posedge clk) begin
        if (!rstn) begin
            seen_reg <= 1'b0;
            strap_reg <= 1'b0;
        end else if (!seen_reg) begin
            seen_reg <= 1'b1;
            strap_reg <= code_space_select_pin;
        end
    end

    // above the internal top always external; strap low means external
    assign internal_hit = (seen_reg ? strap_reg : code_space_select_pin)
        && (code_addr <= `INT_CODE_TOP); // R01 R02 R03
endmodule // code_space_decode
`default_nettype wire

//--- core/ext_bus_defs.svh
// timing and address constants for the external memory bus interface
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH
`define INT_CODE_TOP 16'h1fff
`define ADDR_PH_CYC 4'h2
`define STROBE_CYC 4'h3
`define CNT_ZERO 4'h0
`define BYTE_ZERO 8'h00
`endif

//--- core/ext_bus_pkg.sv
// types shared by the external memory bus interface
`default_nettype none
package ext_bus_pkg;
    typedef enum logic [1:0] {
        op_fetch,
        op_read,
        op_write
    } bus_op_t;
    typedef struct packed {
        bus_op_t op;
        logic [7:0] page;
        logic [7:0] high;
        logic [7:0] low;
        logic [7:0] wdata;
    } bus_req_t;
    typedef struct packed {
        logic [7:0] mux_out;
        logic mux_oe;
        logic [7:0] high_out;
        logic addr_strobe;
        logic fetch_strobe_n;
        logic read_strobe_n;
        logic write_strobe_n;
    } bus_pins_t;
endpackage
`default_nettype wire

//--- core/ext_mem_bus.sv
// external memory bus: code fetch and paged data access over two ports
//
// Functional notes
// R01 - strap high: execution starts at address zero of internal 8K memory
// R02 - strap low: execution starts at address zero of external code
// R03 - code addresses above 1fff always fetched externally
// R04 - both ports fully given over to the bus during external fetch
// R05 - fetch drives pc low byte, then floats mux port for the code
// R06 - address strobe pulses while the low byte is valid on mux port
// R07 - fetch drives pc high byte on high port, then fetch strobe reads
// R08 - external fetch always shows a full 16-bit address
// R09 - data accesses still allowed while running from external code
// R10 - data access latches pointer low byte before data is on bus
// R11 - high port gives page byte at strobe, then pointer high byte
// R12 - without a page latch the memory sees a 64K data space
// R13 - with page latch a 24-bit data address reaches 16M bytes
// R14 - external code space covers 64K bytes
// R15 - fetches and data accesses are independent transaction types
// R16 - data transfers use read or write strobe, never fetch strobe
// R17 - high port holds the high byte through the whole data phase
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defs.svh"
module ext_mem_bus
    import ext_bus_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // strap
    input wire logic code_space_select_pin,
    // request from the core
    input wire logic req_valid,
    input wire bus_req_t req,
    output logic req_ready,
    // answer to the core
    output logic resp_valid,
    output logic resp_internal,
    output logic [7:0] resp_data,
    // pins
    output bus_pins_t pins,
    input wire logic [7:0] multiplexed_bus_port_in
);
    typedef enum logic [1:0] {
        st_idle,
        st_addr,
        st_data
    } state_t;

    state_t state_reg;
    bus_req_t cur_reg;
    logic [3:0] cnt_reg;
    logic internal_hit;
    logic take_int;
    logic take_ext;
    logic addr_last;
    logic strobe_last;
    // one flop per pin group; pins is only a bundle of these
    logic [7:0] mux_out_reg;
    logic mux_oe_reg;
    logic [7:0] high_out_reg;
    logic addr_strobe_reg;
    logic fetch_strobe_n_reg;
    logic read_strobe_n_reg;
    logic write_strobe_n_reg;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // true on the last cycle of a phase of the given length
    function automatic logic phase_end(input logic [3:0] cnt,
        input logic [3:0] len);
        phase_end = (cnt == len - 4'h1);
    endfunction

    // byte for the high port: page while the latches are open on a data op, else high
    function automatic logic [7:0] high_for(input bus_req_t r,
        input logic addr_phase);
        if (addr_phase && r.op != op_fetch)
            high_for = r.page; // R11 R13
        else
            high_for = r.high; // R07 R08 R17
    endfunction

    ////////////////////////////////////////////////////////////////////
    // code space choice
    code_space_decode u_decode (
        .clk(clk),
        .rstn(rstn),
        .code_space_select_pin(code_space_select_pin),
        .code_addr({req.high, req.low}),
        .internal_hit(internal_hit)
    );

    ////////////////////////////////////////////////////////////////////
    // request decode
    // internal fetches are answered at once and never touch the pins
    assign take_int = req_valid && req.op == op_fetch && internal_hit; // R01
    assign take_ext = req_valid && !take_int; // R15 R09
    assign addr_last = phase_end(cnt_reg, `ADDR_PH_CYC);
    assign strobe_last = phase_end(cnt_reg, `STROBE_CYC);

    ////////////////////////////////////////////////////////////////////
    // sequencer: fetch and data ops share one path, in any order
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= st_idle;
        end else begin
            case (state_reg)
                st_idle: begin
                    if (take_ext) begin // R15 R09
                        state_reg <= st_addr;
                    end
                end
                st_addr: begin
                    if (addr_last) begin
                        state_reg <= st_data;
                    end
                end
                st_data: begin
                    if (strobe_last) begin
                        state_reg <= st_idle;
                    end
                end
                default: state_reg <= st_idle;
            endcase
        end
    end

    // phase counter, cleared on every phase change
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= `CNT_ZERO;
        end else begin
            case (state_reg)
                st_addr: begin
                    cnt_reg <= addr_last ? `CNT_ZERO : cnt_reg + 4'h1;
                end
                st_data: begin
                    cnt_reg <= strobe_last ? `CNT_ZERO : cnt_reg + 4'h1;
                end
                default: cnt_reg <= `CNT_ZERO;
            endcase
        end
    end

    // hold the taken request; the core may drop it once answered
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cur_reg <= '0;
        end else if (state_reg == st_idle && take_ext) begin
            cur_reg <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ready only in idle with nothing waiting; advisory for the core
    always_ff @(posedge clk) begin
        if (!rstn) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_reg == st_idle) && !req_valid;
        end
    end

    // one-cycle done pulse, flagged internal when the bus stayed quiet
    always_ff @(posedge clk) begin
        if (!rstn) begin
            resp_valid <= 1'b0;
            resp_internal <= 1'b0;
        end else begin
            resp_valid <= (state_reg == st_idle && take_int)
                || (state_reg == st_data && strobe_last);
            resp_internal <= state_reg == st_idle && take_int; // R01 R02
        end
    end

    // code or data byte taken on the last cycle of the strobe phase, one cycle before the strobe pin rises
    always_ff @(posedge clk) begin
        if (!rstn) begin
            resp_data <= `BYTE_ZERO;
        end else if (state_reg == st_data && strobe_last
            && cur_reg.op != op_write) begin
            resp_data <= multiplexed_bus_port_in; // R07
        end
    end

    ////////////////////////////////////////////////////////////////////
    // multiplexed port: low address byte, then write data or float
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mux_out_reg <= `BYTE_ZERO;
            mux_oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                st_addr: begin
                    mux_out_reg <= cur_reg.low; // R05 R10 R08
                    mux_oe_reg <= 1'b1; // R04
                end
                st_data: begin
                    if (cur_reg.op == op_write) begin
                        mux_out_reg <= cur_reg.wdata; // R10
                        mux_oe_reg <= 1'b1;
                    end else begin
                        mux_oe_reg <= 1'b0; // R05 float for the byte
                    end
                end
                default: mux_oe_reg <= 1'b0;
            endcase
        end
    end

    // high port: page byte under the address strobe on data ops, then high byte; fetches show the high byte throughout
    always_ff @(posedge clk) begin
        if (!rstn) begin
            high_out_reg <= `BYTE_ZERO;
        end else if (state_reg != st_idle) begin
            high_out_reg <= high_for(cur_reg, state_reg == st_addr); // R14
        end
    end

    // address strobe: one pulse at the start of the address phase
    always_ff @(posedge clk) begin
        if (!rstn) begin
            addr_strobe_reg <= 1'b0;
        end else begin
            addr_strobe_reg <= state_reg == st_addr
                && cnt_reg == `CNT_ZERO; // R06
        end
    end

    // fetch, read and write strobes, low through the whole data phase
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fetch_strobe_n_reg <= 1'b1;
            read_strobe_n_reg <= 1'b1;
            write_strobe_n_reg <= 1'b1;
        end else begin
            fetch_strobe_n_reg <= !(state_reg == st_data
                && cur_reg.op == op_fetch); // R07
            read_strobe_n_reg <= !(state_reg == st_data
                && cur_reg.op == op_read); // R16
            write_strobe_n_reg <= !(state_reg == st_data
                && cur_reg.op == op_write); // R16
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin bundle, every field straight from its flop
    assign pins = '{
        mux_out: mux_out_reg,
        mux_oe: mux_oe_reg,
        high_out: high_out_reg,
        addr_strobe: addr_strobe_reg,
        fetch_strobe_n: fetch_strobe_n_reg,
        read_strobe_n: read_strobe_n_reg,
        write_strobe_n: write_strobe_n_reg
    };
endmodule // ext_mem_bus
`default_nettype wire

//--- testbench/ext_mem_bus_props.sv
// pin timing assertions for ext_mem_bus
`timescale 1ns/1ps
`default_nettype none
module ext_mem_bus_props
    import ext_bus_pkg::*;
(
    // clock and answer
    input wire logic clk,
    input wire logic rstn,
    input wire logic resp_valid,
    input wire logic resp_internal,
    // pins
    input wire bus_pins_t pins
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic any_stb;
    // any data or fetch strobe low
    assign any_stb = !(pins.fetch_strobe_n && pins.read_strobe_n
        && pins.write_strobe_n);
    addr_pulse_a: assert property (
        pins.addr_strobe |=> !pins.addr_strobe)
        else $error("address strobe too long");
    addr_driven_a: assert property (
        pins.addr_strobe |-> pins.mux_oe && !any_stb)
        else $error("strobe without driven address");
    fetch_float_a: assert property (
        !pins.fetch_strobe_n |-> !pins.mux_oe)
        else $error("port driven during fetch");
    read_float_a: assert property (
        !pins.read_strobe_n |-> !pins.mux_oe)
        else $error("port driven during read");
    write_drive_a: assert property (
        !pins.write_strobe_n |-> pins.mux_oe && pins.fetch_strobe_n)
        else $error("write without drive");
    addr_then_strobe_a: assert property (
        pins.addr_strobe |-> ##2 any_stb[*3] ##1 !any_stb)
        else $error("strobe phase wrong");
    high_hold_a: assert property (
        any_stb && $past(any_stb) |-> $stable(pins.high_out))
        else $error("high byte moved");
    done_after_a: assert property (
        resp_valid && !resp_internal |-> $past(any_stb))
        else $error("answer without strobe");
    inside_quiet_a: assert property (
        resp_internal |-> resp_valid && !pins.addr_strobe && !any_stb)
        else $error("bus used on internal fetch");
    cover property (pins.addr_strobe ##2 !pins.write_strobe_n);
    cover property (resp_internal);
    cover property (!pins.fetch_strobe_n);
    cover property (!pins.read_strobe_n);
endmodule // ext_mem_bus_props
bind ext_mem_bus ext_mem_bus_props u_props (.clk(clk), .rstn(rstn),
    .resp_valid(resp_valid), .resp_internal(resp_internal), .pins(pins));
`default_nettype wire

//--- testbench/ext_mem_partner.sv
// code memory, address and page latches, paged sram
`timescale 1ns/1ps
`default_nettype none
module ext_mem_partner
    import ext_bus_pkg::*;
(
    // from device
    input wire logic clk,
    input wire bus_pins_t pins,
    // board fit: page latch present on the high port
    input wire logic page_latch_on,
    // to device
    output logic [7:0] mux_in
);
    logic [7:0] lo = 8'h00, pg = 8'h00;
    logic [7:0] ram [int];
    logic [23:0] a;
    assign a = {pg, pins.high_out, lo};
    initial mux_in = 8'h00;
    // latches catch low byte and page, writes land
    always @(posedge clk) begin
        if (pins.addr_strobe) begin
            lo <= pins.mux_out;
            pg <= page_latch_on ? pins.high_out : 8'h00;
        end
        if (!pins.write_strobe_n) ram[a] = pins.mux_out;
    end
    // answer under strobe, else a changing pattern
    always @(posedge clk) begin
        #2;
        if (!pins.fetch_strobe_n) mux_in = lo ^ pins.high_out ^ 8'h5a;
        else if (!pins.read_strobe_n)
            mux_in = ram.exists(a) ? ram[a] : lo ^ pins.high_out ^ pg;
        else mux_in = ~mux_in;
    end
endmodule // ext_mem_partner
`default_nettype wire

//--- testbench/external_memory_bus_interface_tb_top.sv
// self-checking bench for ext_mem_bus
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_interface_tb_top
    import ext_bus_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, strap = 1'b1, req_valid = 1'b0;
    bus_req_t req = '0;
    logic resp_valid, resp_internal, req_ready;
    logic page_latch_on = 1'b1;
    logic [7:0] resp_data, mux_in;
    bus_pins_t pins;
    int errors = 0, n_tests = 0, cyc = 0;
    logic [7:0] ram [int];
    ext_mem_bus DUT (.clk(clk), .rstn(rstn), .code_space_select_pin(strap),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_internal(resp_internal),
        .resp_data(resp_data), .pins(pins), .multiplexed_bus_port_in(mux_in));
    ext_mem_partner mem (.clk(clk), .pins(pins),
        .page_latch_on(page_latch_on), .mux_in(mux_in));
    ////////////////////////////////////////////////////////////////
    initial forever #12.5 clk = ~clk;
    // run limit
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    // one transfer, compared with the model
    task automatic xfer(bus_op_t op, logic [23:0] a, logic [7:0] wd);
        logic [7:0] e;
        logic [23:0] ka;
        int k;
        logic ins;
        ins = op == op_fetch && strap && a[15:0] <= 16'h1fff;
        // without a page latch the memory only sees the low 16 bits
        ka = page_latch_on ? a : {8'h00, a[15:0]};
        @(posedge clk) #1;
        chk("ready", 8'h01, {7'h00, req_ready});
        req = '{op, a[23:16], a[15:8], a[7:0], wd};
        req_valid = 1'b1;
        k = 0;
        do begin
            @(posedge clk) #1;
            k++;
        end while (resp_valid !== 1'b1 && k < 20);
        req_valid = 1'b0;
        chk("latency", ins ? 8'h01 : 8'h06, 8'(k));
        chk("internal", {7'h00, ins}, {7'h00, resp_internal});
        e = op == op_fetch ? a[7:0] ^ a[15:8] ^ 8'h5a :
            ram.exists(ka) ? ram[ka] : ka[7:0] ^ ka[15:8] ^ ka[23:16];
        if (op == op_write) ram[ka] = wd;
        else if (!ins) chk("data", e, resp_data);
    endtask
    initial begin
        logic [23:0] a;
        void'($urandom(32'h7b0a));
        for (int ph = 0; ph < 2; ph++) begin
            strap = ph == 0;
            page_latch_on = ph == 0;
            rstn = 1'b0;
            repeat (16) @(posedge clk);
            #1 rstn = 1'b1;
            xfer(op_fetch, 24'h0, 8'h0);
            xfer(op_fetch, 24'h1fff, 8'h0);
            xfer(op_fetch, 24'h2000, 8'h0);
            for (int i = 0; i < 12; i++) begin
                a = 24'($urandom);
                xfer(op_write, a, 8'($urandom));
                xfer(op_fetch, {8'h0, 3'(i), 13'($urandom)}, 8'h0);
                xfer(op_read, a, 8'h0);
                xfer(op_read, 24'($urandom), 8'h0);
            end
        end
        complete_run();
    end
endmodule // external_memory_bus_interface_tb_top
`default_nettype wire
